// *** hdl/drive_consts.svh ***
// timing counts, limits and function codes for the input-terminal brake and profile block
`ifndef DRIVE_CONSTS_SVH
`define DRIVE_CONSTS_SVH

`define CLK_MHZ           200
`define CLK_PERIOD_NS     5
`define DELAY_UNIT_MS     100
`define DELAY_UNIT_CYCLES (`DELAY_UNIT_MS * 1000 * `CLK_MHZ)
`define RAMP_TICK_NS      1000
`define RAMP_TICK_CYCLES  (`RAMP_TICK_NS / `CLK_PERIOD_NS)
`define DELAY_MAX         6'h32
`define FORCE_MAX         7'h64
`define FN_BRAKE          8'h07
`define FN_MOTOR_SET      8'h08
`define FN_RAMP_SELECT    8'h09
`define METHOD_TERMINAL   2'h0
`define TERMINAL_COUNT    5

`endif

// *** hdl/drive_pkg.sv ***
// types shared by the input-terminal brake and profile block
package drive_pkg;
    typedef enum logic [3:0] {
        st_run   = 4'h1,
        st_coast = 4'h2,
        st_brake = 4'h4,
        st_halt  = 4'h8
    } drive_state_e;

    typedef logic [15:0] freq_t;
endpackage

// *** hdl/term_func_if.sv ***
// decoded terminal functions passed from the terminal decoder to the drive logic
`timescale 1ns/1ps
interface term_func_if;
    logic brake_req;
    logic motor_set_req;
    logic ramp_sel_req;

    modport src (output brake_req, output motor_set_req, output ramp_sel_req);
    modport dst (input brake_req, input motor_set_req, input ramp_sel_req);
endinterface

// *** hdl/term_func_decode.sv ***
// samples the five configurable terminals and maps them to functions by their codes
`timescale 1ns/1ps
`include "drive_consts.svh"
module term_func_decode (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [4:0] terminals_in,
    input  wire logic [7:0] fn_sel_in [`TERMINAL_COUNT],
    term_func_if.src        fn
);
    logic [4:0] term_r;
    logic [4:0] term_nxt;
    logic [4:0] hit_brake;
    logic [4:0] hit_set;
    logic [4:0] hit_ramp;

    always_comb begin
        term_nxt = terminals_in;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            term_r <= 5'h00;
        end else begin
            term_r <= term_nxt;
        end
    end

    // a code may sit on several terminals; any active one asserts the function
    for (genvar i = 0; i < `TERMINAL_COUNT; i++) begin : g_term
        assign hit_brake[i] = term_r[i] && (fn_sel_in[i] == `FN_BRAKE);
        assign hit_set[i]   = term_r[i] && (fn_sel_in[i] == `FN_MOTOR_SET);
        assign hit_ramp[i]  = term_r[i] && (fn_sel_in[i] == `FN_RAMP_SELECT);
        // checked on every terminal so whichever one carries the brake code is watched
        sampled_level_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
            (terminals_in[i] && fn_sel_in[i] == `FN_BRAKE) ##1 (fn_sel_in[i] == `FN_BRAKE) |-> fn.brake_req)
            else $error("brake request did not follow its terminal one cycle later");
    end

    assign fn.brake_req     = |hit_brake;
    assign fn.motor_set_req = |hit_set;
    assign fn.ramp_sel_req  = |hit_ramp;
endmodule

// *** hdl/drive_input_brake.sv ***
// dc injection braking, motor set select and ramp select driven by the input terminals
`timescale 1ns/1ps
`include "drive_consts.svh"
// Summary of operation
// - a terminal coded 07 requests external dc injection braking
// - braking delay setting spans 0.0 to 5.0 seconds in tenths
// - braking force setting spans 0 to 100 percent
// - terminal run: brake applies, on release output ramps back to previous frequency
// - keypad run: after brake release the output stays off
// - delayed case, keypad run only: coast with output off until delay expires, then brake
// - brake input asserted brakes during deceleration; deasserted it does not
// - each function may sit on any of the five configurable terminals
// - code 08 asserted selects second motor set, deasserted the first
// - motor set changes while running are held until the drive stops
// - code 09 asserted selects second accel and decel times, else first
// - ramp select mid-ramp switches rate immediately for the rest of it
// - ramp select counts only when the second-stage method is 00
module drive_input_brake #(
    parameter int unsigned DELAY_UNIT_CYCLES = `DELAY_UNIT_CYCLES
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [4:0]  terminals_in,
    input  wire logic [7:0]  input_one_function_select_in,
    input  wire logic [7:0]  input_two_function_select_in,
    input  wire logic [7:0]  input_three_function_select_in,
    input  wire logic [7:0]  input_four_function_select_in,
    input  wire logic [7:0]  input_five_function_select_in,
    input  wire logic        forward_run_input_in,
    input  wire logic        reverse_run_input_in,
    input  wire logic        run_from_keypad_in,
    input  wire logic        keypad_run_in,
    input  wire logic [15:0] target_freq_in,
    input  wire logic [5:0]  braking_delay_setting_in,
    input  wire logic [6:0]  braking_force_setting_in,
    input  wire logic [15:0] accel_time_first_in,
    input  wire logic [15:0] decel_time_first_in,
    input  wire logic [15:0] accel_time_second_in,
    input  wire logic [15:0] decel_time_second_in,
    input  wire logic [1:0]  second_stage_method_select_in,
    output logic      [15:0] output_freq_out,
    output logic             output_enable_out,
    output logic             dc_brake_active_out,
    output logic      [6:0]  dc_brake_force_out,
    output logic             motor_set_second_out,
    output logic             ramp_second_active_out
);
    localparam logic [7:0] RAMP_LAST = 8'(`RAMP_TICK_CYCLES - 1);
    localparam logic [31:0] UNIT_LAST = 32'(DELAY_UNIT_CYCLES - 1);

    term_func_if fn_if ();
    logic [7:0] fn_sel [`TERMINAL_COUNT];

    assign fn_sel[0] = input_one_function_select_in;
    assign fn_sel[1] = input_two_function_select_in;
    assign fn_sel[2] = input_three_function_select_in;
    assign fn_sel[3] = input_four_function_select_in;
    assign fn_sel[4] = input_five_function_select_in;

    term_func_decode u_decode (
        .ref_clk_in   (ref_clk_in),
        .rst_n_in     (rst_n_in),
        .terminals_in (terminals_in),
        .fn_sel_in    (fn_sel),
        .fn           (fn_if.src)
    );

    drive_pkg::drive_state_e st_r;
    drive_pkg::drive_state_e st_nxt;
    drive_pkg::freq_t        freq_r;
    drive_pkg::freq_t        freq_nxt;
    drive_pkg::freq_t        saved_r;
    drive_pkg::freq_t        saved_nxt;
    logic [15:0]             pace_r;
    logic [15:0]             pace_nxt;
    logic                    resume_r;
    logic                    resume_nxt;
    logic [5:0]              units_r;
    logic [5:0]              units_nxt;
    logic [7:0]              ramp_div_r;
    logic [7:0]              ramp_div_nxt;
    logic [31:0]             unit_div_r;
    logic [31:0]             unit_div_nxt;
    logic [6:0]              force_r;
    logic [6:0]              force_nxt;
    logic                    mset_r;
    logic                    mset_nxt;

    logic              run_cmd;
    logic              ramp_tick;
    logic              unit_tick;
    logic              ramp_second;
    logic              stopped;
    logic [5:0]        delay_eff;
    logic [6:0]        force_eff;
    drive_pkg::freq_t  goal;
    logic [15:0]       rate;

    assign run_cmd     = run_from_keypad_in ? keypad_run_in : (forward_run_input_in || reverse_run_input_in);
    // out-of-range settings are clamped rather than rejected so a bad word cannot overdrive the stage
    assign delay_eff   = (braking_delay_setting_in > `DELAY_MAX) ? `DELAY_MAX : braking_delay_setting_in;
    assign force_eff   = (braking_force_setting_in > `FORCE_MAX) ? `FORCE_MAX : braking_force_setting_in;
    assign ramp_second = fn_if.ramp_sel_req && (second_stage_method_select_in == `METHOD_TERMINAL);
    assign goal        = resume_r ? saved_r : (run_cmd ? target_freq_in : 16'h0000);
    // rate is chosen every step, so a mid-ramp change of the select applies at once
    always_comb begin
        if (goal > freq_r) begin
            rate = ramp_second ? accel_time_second_in : accel_time_first_in;
        end else begin
            rate = ramp_second ? decel_time_second_in : decel_time_first_in;
        end
    end
    assign stopped   = ((st_r == drive_pkg::st_run) && (freq_r == 16'h0000) && !run_cmd) || (st_r == drive_pkg::st_halt);
    assign ramp_tick = (ramp_div_r == RAMP_LAST);
    assign unit_tick = (unit_div_r == UNIT_LAST);

    always_comb begin
        ramp_div_nxt = ramp_tick ? 8'h00 : ramp_div_r + 8'h01;
        unit_div_nxt = (st_r != drive_pkg::st_coast || unit_tick) ? 32'h0000_0000 : unit_div_r + 32'h0000_0001;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ramp_div_r <= 8'h00;
            unit_div_r <= 32'h0000_0000;
        end else begin
            ramp_div_r <= ramp_div_nxt;
            unit_div_r <= unit_div_nxt;
        end
    end

    always_comb begin
        st_nxt     = st_r;
        freq_nxt   = freq_r;
        saved_nxt  = saved_r;
        pace_nxt   = pace_r;
        resume_nxt = resume_r && run_cmd;
        units_nxt  = units_r;
        case (st_r)
            drive_pkg::st_run: begin
                if (fn_if.brake_req) begin
                    saved_nxt = resume_r ? saved_r : freq_r;
                    freq_nxt  = 16'h0000;
                    pace_nxt  = 16'h0000;
                    units_nxt = 6'h00;
                    st_nxt    = (run_from_keypad_in && delay_eff != 6'h00) ? drive_pkg::st_coast : drive_pkg::st_brake;
                end else if (ramp_tick && freq_r != goal) begin
                    if (pace_r >= rate) begin
                        pace_nxt = 16'h0000;
                        freq_nxt = (goal > freq_r) ? freq_r + 16'h0001 : freq_r - 16'h0001;
                    end else begin
                        pace_nxt = pace_r + 16'h0001;
                    end
                end else if (freq_r == goal) begin
                    resume_nxt = 1'b0;
                end
            end
            drive_pkg::st_coast: begin
                if (!fn_if.brake_req) begin
                    st_nxt = drive_pkg::st_halt;
                end else if (unit_tick) begin
                    units_nxt = units_r + 6'h01;
                    if (units_r + 6'h01 >= delay_eff) begin
                        st_nxt = drive_pkg::st_brake;
                    end
                end
            end
            drive_pkg::st_brake: begin
                if (!fn_if.brake_req) begin
                    if (run_from_keypad_in) begin
                        st_nxt = drive_pkg::st_halt;
                    end else begin
                        st_nxt     = drive_pkg::st_run;
                        resume_nxt = run_cmd;
                    end
                end
            end
            drive_pkg::st_halt: begin
                // keypad run must be withdrawn before a new start is accepted
                if (!fn_if.brake_req && !run_cmd) begin
                    st_nxt = drive_pkg::st_run;
                end
            end
            default: begin
                st_nxt = drive_pkg::st_run;
            end
        endcase
        force_nxt = (st_nxt == drive_pkg::st_brake) ? force_eff : 7'h00;
        mset_nxt  = stopped ? fn_if.motor_set_req : mset_r;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r     <= drive_pkg::st_run;
            freq_r   <= 16'h0000;
            saved_r  <= 16'h0000;
            pace_r   <= 16'h0000;
            resume_r <= 1'b0;
            units_r  <= 6'h00;
            force_r  <= 7'h00;
            mset_r   <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            freq_r   <= freq_nxt;
            saved_r  <= saved_nxt;
            pace_r   <= pace_nxt;
            resume_r <= resume_nxt;
            units_r  <= units_nxt;
            force_r  <= force_nxt;
            mset_r   <= mset_nxt;
        end
    end

    assign output_freq_out        = freq_r;
    assign output_enable_out      = (st_r == drive_pkg::st_run) && (run_cmd || freq_r != 16'h0000);
    assign dc_brake_active_out    = (st_r == drive_pkg::st_brake);
    assign dc_brake_force_out     = force_r;
    assign motor_set_second_out   = mset_r;
    assign ramp_second_active_out = ramp_second;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence keypad_release_s;
        (st_r == drive_pkg::st_brake) && !fn_if.brake_req && run_from_keypad_in;
    endsequence
    sequence held_off_s;
        (st_r == drive_pkg::st_halt) && !output_enable_out && !dc_brake_active_out;
    endsequence

    brake_entry_a: assert property (
        (st_r == drive_pkg::st_run) && fn_if.brake_req && !run_from_keypad_in |=> dc_brake_active_out
        ##0 dc_brake_force_out == $past(force_eff)) else $error("brake not applied after request");
    delay_range_a: assert property (delay_eff <= `DELAY_MAX) else $error("braking delay above limit");
    force_range_a: assert property (dc_brake_force_out <= `FORCE_MAX &&
        (!dc_brake_active_out -> dc_brake_force_out == 7'h00)) else $error("braking force wrong");
    terminal_resume_a: assert property (
        (st_r == drive_pkg::st_brake) && !fn_if.brake_req && !run_from_keypad_in && run_cmd
        |=> (st_r == drive_pkg::st_run) && resume_r && goal == saved_r) else $error("no ramp back after brake");
    keypad_halt_a: assert property (keypad_release_s |=> held_off_s)
        else $error("output resumed after keypad brake release");
    coast_off_a: assert property ((st_r == drive_pkg::st_coast) |-> !output_enable_out && !dc_brake_active_out
        && units_r < delay_eff) else $error("coast phase drove output or overran delay");
    no_brake_a: assert property ((st_r == drive_pkg::st_run) && !fn_if.brake_req |=> !dc_brake_active_out)
        else $error("brake without request");
    set_hold_a: assert property (!stopped |=> $stable(motor_set_second_out))
        else $error("motor set changed while running");
    set_follow_a: assert property (stopped |=> motor_set_second_out == $past(fn_if.motor_set_req))
        else $error("motor set not taken while stopped");
    ramp_method_a: assert property (second_stage_method_select_in != `METHOD_TERMINAL |-> !ramp_second_active_out)
        else $error("ramp select honoured with wrong method");
endmodule

// *** bench/terminal_driver.sv ***
// model of the external controller that drives the configurable input terminals
`timescale 1ns/1ps
module terminal_driver #(
    parameter int unsigned MAX_HOLD = 4000
) (
    input  wire logic       ref_clk_in,
    input  wire logic [4:0] want_in,
    input  wire logic [4:0] brake_mask_in,
    output logic      [4:0] terminals_out
);
    int unsigned held_r = 0;
    // contacts change just after an edge; a brake request is dropped after a bounded hold
    always @(posedge ref_clk_in) begin
        held_r        <= ((want_in & brake_mask_in) != 5'h00) ? held_r + 1 : 0;
        terminals_out <= (held_r >= MAX_HOLD) ? (want_in & ~brake_mask_in) : want_in;
    end
endmodule

// *** bench/drive_input_brake_tb.sv ***
// self-checking bench for the terminal brake, motor set and ramp select block
`timescale 1ns/1ps
module drive_input_brake_tb;
    logic        ref_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [4:0]  want = 5'h00;
    logic [4:0]  bmask = 5'h00;
    logic [4:0]  terminals;
    logic [7:0]  fsel [5];
    logic        fwd = 1'b0, rev = 1'b0, from_kp = 1'b0, kp_run = 1'b0;
    logic [15:0] target = 16'h0004, acc1 = 16'h0000, dec1 = 16'h0000, acc2 = 16'h0000, dec2 = 16'h0000;
    logic [5:0]  delay = 6'h00;
    logic [6:0]  force_set = 7'h00;
    logic [1:0]  method = 2'h0;
    logic [15:0] freq;
    logic [15:0] tgt;
    logic [6:0]  force_out;
    logic        oe, brk, mset, rsec;
    int          num_errors = 0, n_tests = 0, seed = 32'he190, b, s, r, d;

    initial forever #2.5 ref_clk_in = ~ref_clk_in;

    terminal_driver terminal_driver_i (.ref_clk_in(ref_clk_in), .want_in(want), .brake_mask_in(bmask),
        .terminals_out(terminals));
    drive_input_brake #(.DELAY_UNIT_CYCLES(20)) drive_input_brake_i (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .terminals_in(terminals),
        .input_one_function_select_in(fsel[0]), .input_two_function_select_in(fsel[1]),
        .input_three_function_select_in(fsel[2]), .input_four_function_select_in(fsel[3]),
        .input_five_function_select_in(fsel[4]), .forward_run_input_in(fwd), .reverse_run_input_in(rev),
        .run_from_keypad_in(from_kp), .keypad_run_in(kp_run), .target_freq_in(target),
        .braking_delay_setting_in(delay), .braking_force_setting_in(force_set),
        .accel_time_first_in(acc1), .decel_time_first_in(dec1), .accel_time_second_in(acc2),
        .decel_time_second_in(dec2), .second_stage_method_select_in(method), .output_freq_out(freq),
        .output_enable_out(oe), .dc_brake_active_out(brk), .dc_brake_force_out(force_out),
        .motor_set_second_out(mset), .ramp_second_active_out(rsec));

    function automatic logic [6:0] exp_force(input logic [6:0] f);
        return (f > 7'h64) ? 7'h64 : f;
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    // which: 0 frequency, 1 brake active, 2 second motor set
    task automatic wait_for(input string what, input int which, input logic [15:0] v, input int bound);
        logic [15:0] got;
        for (int i = 0; i <= bound; i++) begin
            @(negedge ref_clk_in);
            got = (which == 0) ? freq : (which == 1) ? {15'h0, brk} : {15'h0, mset};
            if (got === v) return;
        end
        chk(what, v, got);
        end_of_test();
    endtask

    initial begin
        for (int i = 0; i < 5; i++) fsel[i] = 8'h0a;
        cyc(5);
        rst_n_in <= 1'b1;
        @(negedge ref_clk_in);
        chk("reset freq", 16'h0, freq);
        chk("reset brake", 16'h0, {15'h0, brk});
        chk("reset force", 16'h0, {9'h0, force_out});
        chk("reset motor set", 16'h0, {15'h0, mset});
        b = {$random(seed)} % 5;
        s = (b + 1) % 5;
        r = (b + 2 + {$random(seed)} % 3) % 5;
        @(posedge ref_clk_in);
        fsel[b] <= 8'h07;
        fsel[s] <= 8'h08;
        fsel[r] <= 8'h09;
        bmask <= 5'h01 << b;
        rev <= 1'b1;
        tgt = 16'h0001 + 16'({$random(seed)} % 8);
        target <= tgt;
        force_set <= $random(seed);
        acc1 <= {$random(seed)} % 2;
        dec1 <= {$random(seed)} % 2;
        wait_for("terminal run freq", 0, tgt, 6000);
        d = (b + 1 + {$random(seed)} % 4) % 5;
        if (d == s || d == r) d = b;
        if (d != b) begin
            want[d] <= 1'b1;
            cyc(6);
            chk("brake off for other code", 16'h0, {15'h0, brk});
            want[d] <= 1'b0;
        end
        want[b] <= 1'b1;
        wait_for("brake applied", 1, 16'h1, 4);
        chk("brake force", {9'h0, exp_force(force_set)}, {9'h0, force_out});
        chk("output off braking", 16'h0, {15'h0, oe});
        @(posedge ref_clk_in);
        want[b] <= 1'b0;
        wait_for("brake released", 1, 16'h0, 4);
        chk("output back on", 16'h1, {15'h0, oe});
        wait_for("resume to previous freq", 0, target, 6000);
        $display("test terminal brake done");
        @(posedge ref_clk_in);
        rev <= 1'b0;
        fwd <= 1'b1;
        want[s] <= 1'b1;
        cyc(8);
        chk("motor set held while running", 16'h0, {15'h0, mset});
        fwd <= 1'b0;
        wait_for("stopped", 0, 16'h0, 6000);
        wait_for("motor set after stop", 2, 16'h1, 4);
        want[s] <= 1'b0;
        wait_for("motor set first again", 2, 16'h0, 4);
        $display("test motor set done");
        @(posedge ref_clk_in);
        method <= 2'h1;
        want[r] <= 1'b1;
        cyc(4);
        chk("ramp select wrong method", 16'h0, {15'h0, rsec});
        method <= 2'h0;
        cyc(2);
        chk("ramp select terminal method", 16'h1, {15'h0, rsec});
        want[r] <= 1'b0;
        acc1 <= 16'h000f;
        acc2 <= 16'h0000;
        target <= 16'h0004;
        cyc(4);
        chk("ramp select released", 16'h0, {15'h0, rsec});
        fwd <= 1'b1;
        wait_for("slow first step", 0, 16'h1, 4000);
        @(posedge ref_clk_in);
        want[r] <= 1'b1;
        wait_for("fast rate mid ramp", 0, 16'h2, 600);
        @(posedge ref_clk_in);
        fwd <= 1'b0;
        want[r] <= 1'b0;
        wait_for("stopped again", 0, 16'h0, 6000);
        $display("test ramp select done");
        @(posedge ref_clk_in);
        acc1 <= 16'h0000;
        d = 1 + {$random(seed)} % 3;
        delay <= d;
        target <= 16'h0003;
        from_kp <= 1'b1;
        kp_run <= 1'b1;
        wait_for("keypad run freq", 0, 16'h3, 3000);
        @(posedge ref_clk_in);
        want[b] <= 1'b1;
        cyc(d * 20 - 2);
        chk("coast brake off", 16'h0, {15'h0, brk});
        chk("coast output off", 16'h0, {15'h0, oe});
        wait_for("brake after delay", 1, 16'h1, 15);
        @(posedge ref_clk_in);
        want[b] <= 1'b0;
        cyc(8);
        chk("keypad output stays off", 16'h0, {15'h0, oe});
        chk("keypad brake off", 16'h0, {15'h0, brk});
        $display("test keypad delayed brake done");
        end_of_test();
    end
endmodule
